// ===== rtl/patch_sysreg_defines.vh
`ifndef PATCH_SYSREG_DEFINES_VH
`define PATCH_SYSREG_DEFINES_VH

// Common operand fields of the whole bank
`define SR_OP0          2'h3
`define SR_OP1          3'h6
`define SR_CRN          4'hf
// Register selectors
`define SR_CRM_ATCR     4'h7
`define SR_OP2_ATCR     3'h0
`define SR_CRM_PATCH    4'h8
`define SR_OP2_INDEX    3'h0
`define SR_OP2_CONTROL  3'h1
`define SR_OP2_OPCODE   3'h2
`define SR_OP2_MASK     3'h3
`define SR_OP2_OPEXCL   3'h4
`define SR_OP2_MASKEXCL 3'h5
`define SR_OP2_FLAGS    3'h6
// Highest privilege level
`define SR_EL_TOP       2'h3
// Widths and reset values
`define SR_WIDTH        64
`define SR_RESET        64'h0000000000000000
`define PATCH_ENTRIES   8
`define PATCH_SEL_BITS  3
// Entry memory: field slot within an entry
`define SLOT_CONTROL    3'h0
`define SLOT_OPCODE     3'h1
`define SLOT_MASK       3'h2
`define SLOT_OPEXCL     3'h3
`define SLOT_MASKEXCL   3'h4
`define SLOT_FLAGS      3'h5
// Translation control fields
`define ATCR_EN_LSB     0
`define ATCR_VAL_LSB    8
`define ATCR_FIELD_BITS 4
`define ATCR_WR_MASK    64'h0000000000000f0f

`endif

// ===== rtl/patch_entry_mem.v
`timescale 1ns/100ps
`include "patch_sysreg_defines.vh"

module patch_entry_mem (
	clk,
	sys_rst,
	wrEn,
	addr,
	wrData,
	rdData
);
	input  wire        clk;
	input  wire        sys_rst;
	input  wire        wrEn;
	input  wire [5:0]  addr;
	input  wire [63:0] wrData;
	output reg  [63:0] rdData;

	reg  [63:0] mem_r [0:63];
	integer     i;

	// Cleared on reset so that no entry is live
	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			for (i = 0; i < 64; i = i + 1) begin
				mem_r[i] <= `SR_RESET;
			end
			rdData <= `SR_RESET;
		end else begin
			if (wrEn) begin
				mem_r[addr] <= wrData;
			end
			rdData <= wrEn ? wrData : mem_r[addr];
		end
	end
endmodule // patch_entry_mem

// ===== rtl/patch_sysreg_bank.v
`timescale 1ns/100ps
`include "patch_sysreg_defines.vh"

module patch_sysreg_bank (
	clk,
	sys_rst,
	reqValid,
	reqWrite,
	reqOp0,
	reqOp1,
	reqCrn,
	reqCrm,
	reqOp2,
	curPrivLevel,
	reqWrData,
	respValid,
	respUndef,
	respRdData,
	walkAttrBits,
	patchIndex
);
	input  wire        clk;
	input  wire        sys_rst;
	input  wire        reqValid;
	input  wire        reqWrite;
	input  wire [1:0]  reqOp0;
	input  wire [2:0]  reqOp1;
	input  wire [3:0]  reqCrn;
	input  wire [3:0]  reqCrm;
	input  wire [2:0]  reqOp2;
	input  wire [1:0]  curPrivLevel;
	input  wire [63:0] reqWrData;
	output reg         respValid;
	output reg         respUndef;
	output wire [63:0] respRdData;
	output reg  [3:0]  walkAttrBits;
	output reg  [63:0] patchIndex;

	////////////////////////////////////////////////////////////////////////////////
	// Decode
	reg  [63:0] atcr_r;
	reg         hit;
	reg         isAtcr;
	reg         isIndex;
	reg         isEntry;
	reg  [2:0]  slot;
	wire        inSpace;
	wire        allowed;
	wire        doAccess;
	wire        entryWr;
	wire [5:0]  memAddr;
	wire [63:0] memRdData;
	reg  [63:0] regRd_r;
	reg         fromMem_r;

	assign inSpace = (reqOp0 == `SR_OP0) && (reqOp1 == `SR_OP1) && (reqCrn == `SR_CRN);

	always @* begin
		isAtcr  = 1'b0;
		isIndex = 1'b0;
		isEntry = 1'b0;
		slot    = `SLOT_CONTROL;
		if (inSpace && reqCrm == `SR_CRM_ATCR && reqOp2 == `SR_OP2_ATCR) begin
			isAtcr = 1'b1;
		end else if (inSpace && reqCrm == `SR_CRM_PATCH && reqOp2 == `SR_OP2_INDEX) begin
			isIndex = 1'b1;
		end else if (inSpace && reqCrm == `SR_CRM_PATCH && reqOp2 == `SR_OP2_CONTROL) begin
			isEntry = 1'b1;
			slot    = `SLOT_CONTROL;
		end else if (inSpace && reqCrm == `SR_CRM_PATCH && reqOp2 == `SR_OP2_OPCODE) begin
			isEntry = 1'b1;
			slot    = `SLOT_OPCODE;
		end else if (inSpace && reqCrm == `SR_CRM_PATCH && reqOp2 == `SR_OP2_MASK) begin
			isEntry = 1'b1;
			slot    = `SLOT_MASK;
		end else if (inSpace && reqCrm == `SR_CRM_PATCH && reqOp2 == `SR_OP2_OPEXCL) begin
			isEntry = 1'b1;
			slot    = `SLOT_OPEXCL;
		end else if (inSpace && reqCrm == `SR_CRM_PATCH && reqOp2 == `SR_OP2_MASKEXCL) begin
			isEntry = 1'b1;
			slot    = `SLOT_MASKEXCL;
		end else if (inSpace && reqCrm == `SR_CRM_PATCH && reqOp2 == `SR_OP2_FLAGS) begin
			isEntry = 1'b1;
			slot    = `SLOT_FLAGS;
		end
		hit = isAtcr | isIndex | isEntry;
	end

	// Only the top level may touch the bank
	assign allowed  = (curPrivLevel == `SR_EL_TOP);
	assign doAccess = reqValid && hit && allowed;
	assign entryWr  = doAccess && reqWrite && isEntry;
	// Entry index taken from low bits of the index register
	assign memAddr  = {patchIndex[`PATCH_SEL_BITS-1:0], slot};

	////////////////////////////////////////////////////////////////////////////////
	// Storage, present unconditionally in every build
	patch_entry_mem u_mem (
		.clk    (clk),
		.sys_rst(sys_rst),
		.wrEn   (entryWr),
		.addr   (memAddr),
		.wrData (reqWrData),
		.rdData (memRdData)
	);

	always @(posedge clk or posedge sys_rst) begin
		if (sys_rst) begin
			atcr_r       <= `SR_RESET;
			patchIndex   <= `SR_RESET;
			respValid    <= 1'b0;
			respUndef    <= 1'b0;
			regRd_r      <= `SR_RESET;
			fromMem_r    <= 1'b0;
			walkAttrBits <= 4'h0;
		end else begin
			respValid <= reqValid;
			respUndef <= reqValid && !(hit && allowed);
			fromMem_r <= doAccess && !reqWrite && isEntry;
			regRd_r   <= `SR_RESET;
			if (doAccess && reqWrite && isAtcr) begin
				atcr_r <= reqWrData & `ATCR_WR_MASK;
			end
			if (doAccess && reqWrite && isIndex) begin
				patchIndex <= reqWrData;
			end
			if (doAccess && !reqWrite && isAtcr) begin
				regRd_r <= atcr_r;
			end
			if (doAccess && !reqWrite && isIndex) begin
				regRd_r <= patchIndex;
			end
			// Disabled attribute bits drive zero on walks
			walkAttrBits <= atcr_r[`ATCR_VAL_LSB +: `ATCR_FIELD_BITS]
				& atcr_r[`ATCR_EN_LSB +: `ATCR_FIELD_BITS];
		end
	end

	// Both sources are registers; mux selects the one that answered
	assign respRdData = fromMem_r ? memRdData : regRd_r;
endmodule // patch_sysreg_bank

// ===== tb/patch_sysreg_bank_properties.sv
`timescale 1ns/100ps
module patch_sysreg_bank_properties (
	input logic        clk,
	input logic        sys_rst,
	input logic        reqValid,
	input logic        reqWrite,
	input logic [1:0]  reqOp0,
	input logic [2:0]  reqOp1,
	input logic [3:0]  reqCrn,
	input logic [3:0]  reqCrm,
	input logic [2:0]  reqOp2,
	input logic [1:0]  curPrivLevel,
	input logic [63:0] reqWrData,
	input logic        respValid,
	input logic        respUndef,
	input logic [63:0] respRdData,
	input logic [3:0]  walkAttrBits,
	input logic [63:0] patchIndex
);
	default clocking @(posedge clk); endclocking
	default disable iff (sys_rst);
	wire sp = reqOp0 == 2'h3 && reqOp1 == 3'h6 && reqCrn == 4'hf;
	wire ok = reqValid && curPrivLevel == 2'h3 && sp;
	wire lo = reqValid && curPrivLevel != 2'h3;
	sequence s_atcr_set;
		ok && reqWrite && reqCrm == 4'h7 && reqOp2 == 3'h0 ##1 1'b1;
	endsequence
	a_resp_one_cycle: assert property (reqValid |=> respValid)
		else $error("no answer");
	a_no_stray: assert property (!reqValid |=> !respValid)
		else $error("stray answer");
	a_low_undef: assert property (lo |=> respUndef)
		else $error("low level taken");
	a_low_keep: assert property (lo && reqWrite |=> $stable(patchIndex))
		else $error("low level wrote");
	a_index_write: assert property (ok && reqWrite && reqCrm == 4'h8 && reqOp2 == 3'h0
		|=> patchIndex == $past(reqWrData)) else $error("index lost");
	a_patch_known: assert property (ok && reqCrm == 4'h8 && reqOp2 != 3'h7 |=> !respUndef)
		else $error("patch refused");
	a_enc_undef: assert property (reqValid && !(sp && reqCrm inside {4'h7, 4'h8})
		|=> respUndef) else $error("bad code taken");
	a_undef_zero: assert property (respUndef |-> respRdData == 64'h0)
		else $error("undef data");
	a_attr_gate: assert property (s_atcr_set
		|=> walkAttrBits == ($past(reqWrData[11:8], 2) & $past(reqWrData[3:0], 2)))
		else $error("walk bits");
endmodule // patch_sysreg_bank_properties
bind patch_sysreg_bank patch_sysreg_bank_properties chk_u (.clk(clk), .sys_rst(sys_rst),
	.reqValid(reqValid), .reqWrite(reqWrite), .reqOp0(reqOp0), .reqOp1(reqOp1),
	.reqCrn(reqCrn), .reqCrm(reqCrm), .reqOp2(reqOp2), .curPrivLevel(curPrivLevel),
	.reqWrData(reqWrData), .respValid(respValid), .respUndef(respUndef),
	.respRdData(respRdData), .walkAttrBits(walkAttrBits), .patchIndex(patchIndex));

// ===== tb/patch_sysreg_bank_tb.sv
`timescale 1ns/100ps
module patch_sysreg_bank_tb;
	reg         clk = 1'b0, sys_rst = 1'b1, reqValid = 1'b0, reqWrite = 1'b0, undefVal;
	reg  [1:0]  reqOp0 = 2'h3, curPrivLevel = 2'h3;
	reg  [2:0]  reqOp1 = 3'h6, reqOp2 = 3'h0;
	reg  [3:0]  reqCrn = 4'hf, reqCrm = 4'h8;
	reg  [63:0] reqWrData = 64'h0, rdVal;
	wire        respValid, respUndef;
	wire [3:0]  walkAttrBits;
	wire [63:0] respRdData, patchIndex;
	integer     errors = 0, n_compared = 0, e, k;
	always #20 clk = ~clk;
	patch_sysreg_bank dut_u (.clk(clk), .sys_rst(sys_rst), .reqValid(reqValid),
		.reqWrite(reqWrite), .reqOp0(reqOp0), .reqOp1(reqOp1), .reqCrn(reqCrn),
		.reqCrm(reqCrm), .reqOp2(reqOp2), .curPrivLevel(curPrivLevel), .reqWrData(reqWrData),
		.respValid(respValid), .respUndef(respUndef), .respRdData(respRdData),
		.walkAttrBits(walkAttrBits), .patchIndex(patchIndex));
	////////////////////////////////////////////////////////////////////////////////
	task chk(input [63:0] got, input [63:0] exp);
		begin
			n_compared = n_compared + 1;
			if (got !== exp) begin
				errors = errors + 1;
				$display("mismatch t=%0t got %h exp %h", $time, got, exp);
			end
		end
	endtask
	task acc(input wr, input [3:0] crm, input [2:0] op2, input [1:0] lvl, input [63:0] d);
		begin
			@(posedge clk);
			reqValid <= 1'b1;
			reqWrite <= wr;
			reqCrm <= crm;
			reqOp2 <= op2;
			curPrivLevel <= lvl;
			reqWrData <= d;
			@(posedge clk);
			reqValid <= 1'b0;
			@(negedge clk);
			chk({63'h0, respValid}, 64'h1);
			rdVal = respRdData;
			undefVal = respUndef;
		end
	endtask
	////////////////////////////////////////////////////////////////////////////////
	task t_entries;
		begin
			acc(1'b0, 4'h8, 3'h1, 2'h3, 64'h0);
			chk(rdVal, 64'h0);
			for (e = 0; e < 8; e = e + 1) begin
				acc(1'b1, 4'h8, 3'h0, 2'h3, e);
				for (k = 1; k < 7; k = k + 1)
					acc(1'b1, 4'h8, k, 2'h3, {56'ha5, e[3:0], k[3:0]});
			end
			for (e = 0; e < 8; e = e + 1) begin
				acc(1'b1, 4'h8, 3'h0, 2'h3, e);
				acc(1'b0, 4'h8, 3'h0, 2'h3, 64'h0);
				chk(rdVal, e);
				for (k = 1; k < 7; k = k + 1) begin
					acc(1'b0, 4'h8, k, 2'h3, 64'h0);
					chk(rdVal, {56'ha5, e[3:0], k[3:0]});
				end
			end
			$display("entries done");
		end
	endtask
	task t_low;
		begin
			for (e = 0; e < 3; e = e + 1) begin
				acc(1'b1, 4'h8, 3'h2, e, 64'hffffffffffffffff);
				chk(undefVal, 1'b1);
				acc(1'b0, 4'h8, 3'h2, e, 64'h0);
				chk(undefVal, 1'b1);
			end
			acc(1'b0, 4'h8, 3'h2, 2'h3, 64'h0);
			chk(rdVal, {56'ha5, 4'h7, 4'h2});
			$display("low level done");
		end
	endtask
	task t_atcr;
		begin
			acc(1'b0, 4'h7, 3'h0, 2'h3, 64'h0);
			chk(rdVal, 64'h0);
			acc(1'b1, 4'h7, 3'h0, 2'h3, 64'hffffffffffffffff);
			acc(1'b0, 4'h7, 3'h0, 2'h3, 64'h0);
			chk(rdVal, 64'hf0f);
			chk(walkAttrBits, 4'hf);
			acc(1'b1, 4'h7, 3'h0, 2'h3, 64'h30c);
			acc(1'b0, 4'h9, 3'h0, 2'h3, 64'h0);
			chk(walkAttrBits, 4'h0);
			chk(undefVal, 1'b1);
			$display("translation done");
		end
	endtask
	task tally_and_finish;
		begin
			$display("compared %0d mismatches %0d", n_compared, errors);
			if (errors == 0 && n_compared > 0)
				$display("[ PASS ]");
			else
				$display("[ FAIL ]");
			$finish;
		end
	endtask
	initial begin
		#100000;
		errors = errors + 1;
		tally_and_finish;
	end
	initial begin
		repeat (20) @(posedge clk);
		sys_rst <= 1'b0;
		t_entries;
		t_low;
		t_atcr;
		tally_and_finish;
	end
endmodule // patch_sysreg_bank_tb
